/* File: ord_register_map_decoder.sv */
`default_nettype none

// Overview of operation
// - extended registers decoded only in external data space
// - containers of 1, 2, 4 bytes, big-endian
// - wide register: four bytes, lsb at base+3
// - empty top container byte reads zero
// - fields sit low; upper bits zero, unwritable
// - amp capacitor: 9 bits, bits 15:9 zero
// - undefined special addresses reserved, not relied on
// - special region answers direct addresses 0x80-0xFF
// - bit access only where address ends 0/8
module ord_register_map_decoder
  import ord_pkg::*;
#(
  parameter int unsigned FC_WIDTH = 32
)(
  input  wire logic                            clock,
  input  wire logic                            arst_n,
  input  wire ord_sfr_req_s                    sfr_req,
  output logic [7:0]                           sfr_rdata,
  output logic                                 sfr_claim,
  input  wire ord_x_req_s                      x_req,
  output logic [7:0]                           x_rdata,
  output logic                                 x_claim,
  input  wire logic [7:0]                      bit_read_value,
  input  wire logic [FC_WIDTH-1:0]             freq_counter_result,
  input  wire logic [OTP_BYTES-1:0][7:0]       otp_read_bytes,
  output logic [SFR_COUNT-1:0][7:0]            sfr_values,
  output ord_xregs_s                           extended_register_region_values
);

  ord_state_s           state;
  ord_state_s           next_state;
  logic [SFR_COUNT-1:0] sfr_hit;
  logic                 sfr_in_region;
  logic                 sfr_bit_ok;
  logic                 sfr_ro_hit;
  logic [31:0]          fc_word;
  logic                 x_in_region;

  genvar gi;
  generate
    for (gi = 0; gi < SFR_COUNT; gi++)
    begin : g_sfr_hit
      assign sfr_hit[gi] = (sfr_req.addr == SFR_MAP[gi]);
    end
  endgenerate

  assign sfr_in_region = (sfr_req.addr >= SFR_REGION_BASE);
  assign sfr_ro_hit    = (sfr_req.addr == SFR_BIT_READ_VALUE);
  assign sfr_bit_ok    = (sfr_req.addr[3:0] == SFR_BIT_NIBBLE_LO) || (sfr_req.addr[3:0] == SFR_BIT_NIBBLE_HI);
  // unused high bits of a narrow counter come in as zero
  assign fc_word       = 32'(freq_counter_result);
  assign x_in_region   = (x_req.addr >= EXTENDED_REGISTER_REGION_BASE) && (x_req.addr <= EXTENDED_REGISTER_REGION_LAST);

  assign sfr_claim = sfr_in_region && ((|sfr_hit) || sfr_ro_hit);
  assign x_claim   = x_in_region;

  always_comb
  begin
    logic [7:0] sfr_byte;
    logic [7:0] x_byte;
    sfr_byte   = 8'h00;
    x_byte     = 8'h00;
    next_state = state;

    // special function region
    if (sfr_in_region)
    begin
      for (int i = 0; i < SFR_COUNT; i++)
      begin
        if (sfr_hit[i])
        begin
          if (sfr_req.bit_op)
          begin
            // bit operations elsewhere are dropped; reads give zero
            if (sfr_bit_ok)
            begin
              sfr_byte = {7'h00, state.special_function_region[i][sfr_req.bit_sel]};
              if (sfr_req.wr)
              begin
                next_state.special_function_region[i][sfr_req.bit_sel] = sfr_req.wdata[0];
              end
            end
          end
          else
          begin
            sfr_byte = state.special_function_region[i];
            if (sfr_req.wr)
            begin
              next_state.special_function_region[i] = sfr_req.wdata;
            end
          end
        end
      end
      // read-only byte: writes ignored, live value returned
      if (sfr_ro_hit && !sfr_req.bit_op)
      begin
        sfr_byte = bit_read_value;
      end
    end
    // undefined addresses fall through with zero, no storage touched
    if (sfr_req.rd)
    begin
      next_state.sfr_rdata = sfr_byte;
    end

    // extended register region, big-endian containers
    if (x_in_region)
    begin
      if (x_req.addr[15:2] == EXTENDED_REGISTER_REGION_FC_RESULT[15:2])
      begin
        case (x_req.addr[1:0])
          2'h0:    x_byte = fc_word[31:24];
          2'h1:    x_byte = fc_word[23:16];
          2'h2:    x_byte = fc_word[15:8];
          default: x_byte = fc_word[7:0];
        endcase
      end
      else if (x_req.addr[15:4] == EXTENDED_REGISTER_REGION_OTP_READ[15:4])
      begin
        x_byte = otp_read_bytes[x_req.addr[3:0]];
      end
      else
      begin
        case (x_req.addr)
          EXTENDED_REGISTER_REGION_LPOSC_TRIM:
          begin
            x_byte = state.x.lposc_trim;
            if (x_req.wr)
            begin
              next_state.x.lposc_trim = x_req.wdata;
            end
          end
          EXTENDED_REGISTER_REGION_PA_CAP:
          begin
            // msb byte at the lower address; only bit 8 is stored
            x_byte = 8'(state.x.pa_cap >> 8);
            if (x_req.wr)
            begin
              next_state.x.pa_cap[PA_CAP_WIDTH-1:8] = x_req.wdata[PA_CAP_WIDTH-9:0];
            end
          end
          EXTENDED_REGISTER_REGION_PA_CAP + 16'h0001:
          begin
            x_byte = state.x.pa_cap[7:0];
            if (x_req.wr)
            begin
              next_state.x.pa_cap[7:0] = x_req.wdata;
            end
          end
          EXTENDED_REGISTER_REGION_PA_TRIM:
          begin
            x_byte = state.x.pa_trim;
            if (x_req.wr)
            begin
              next_state.x.pa_trim = x_req.wdata;
            end
          end
          EXTENDED_REGISTER_REGION_XO_CTRL:
          begin
            x_byte = state.x.xo_ctrl;
            if (x_req.wr)
            begin
              next_state.x.xo_ctrl = x_req.wdata;
            end
          end
          default:
          begin
            x_byte = 8'h00;
          end
        endcase
      end
    end
    if (x_req.rd)
    begin
      next_state.x_rdata = x_byte;
    end
  end

  // every stored byte starts at zero; peripherals own real defaults
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign sfr_rdata   = state.sfr_rdata;
  assign x_rdata     = state.x_rdata;
  assign sfr_values  = state.special_function_region;
  assign extended_register_region_values = state.x;

endmodule

`default_nettype wire

/* File: ord_pkg.sv */
`default_nettype none

package ord_pkg;

  // special function region: direct-mode addresses from the base up to 0xFF
  localparam logic [7:0]  SFR_REGION_BASE    = 8'h80;
  localparam logic [3:0]  SFR_BIT_NIBBLE_LO  = 4'h0;
  localparam logic [3:0]  SFR_BIT_NIBBLE_HI  = 4'h8;
  localparam logic [7:0]  SFR_BIT_READ_VALUE = 8'h99;
  localparam int unsigned SFR_COUNT          = 41;

  // read/write special function registers, entry 0 at the right-hand end
  localparam logic [SFR_COUNT-1:0][7:0] SFR_MAP = {
    8'hF6,  // extended_irq_priority
    8'hEE,  // system_setup
    8'hE6,  // extended_irq_enable
    8'hE4,  // fsk_deviation
    8'hDD,  // startup_status
    8'hDA,  // protection_control
    8'hCE,  // amplifier_level
    8'hCD,  // timer2_count_high
    8'hCC,  // timer2_count_low
    8'hCB,  // timer2_reload_high
    8'hCA,  // timer2_reload_low
    8'hC9,  // timer_source_select
    8'hC8,  // timer2_control
    8'hBF,  // interrupt_pending_bits
    8'hBE,  // system_clock_generator
    8'hB7,  // pin_interrupt_config
    8'hB6,  // pin_port_options
    8'hB5,  // pin_port_control
    8'hB2,  // general_purpose_value
    8'hB1,  // general_purpose_control
    8'hAF,  // serializer_osc_warmup
    8'hAE,  // serializer_amp_divider_warmup
    8'hAD,  // serializer_rate_high
    8'hAC,  // serializer_rate_low
    8'hAB,  // serializer_payload
    8'hAA,  // serializer_timing
    8'hA9,  // serializer_control
    8'hA5,  // port1_pin_config
    8'hA4,  // port0_pin_config
    8'h9D,  // freq_counter_window
    8'h9C,  // real_time_clock_control
    8'h9B,  // freq_counter_control
    8'h95,  // timer3_count_high
    8'h94,  // timer3_count_low
    8'h93,  // timer3_reload_high
    8'h92,  // timer3_reload_low
    8'h91,  // timer3_control
    8'h8F,  // clock_output_setup
    8'h86,  // aes_substitution_value
    8'h85,  // aes_field_mult_constant
    8'h84   // aes_field_mult_operand
  };

  // extended register region inside the external data space
  localparam logic [15:0] EXTENDED_REGISTER_REGION_BASE        = 16'h4000;
  localparam logic [15:0] EXTENDED_REGISTER_REGION_LAST        = 16'h404F;
  localparam logic [15:0] EXTENDED_REGISTER_REGION_LPOSC_TRIM  = 16'h4002;
  localparam logic [15:0] EXTENDED_REGISTER_REGION_FC_RESULT   = 16'h4008;
  localparam logic [15:0] EXTENDED_REGISTER_REGION_PA_CAP      = 16'h400C;
  localparam logic [15:0] EXTENDED_REGISTER_REGION_PA_TRIM     = 16'h4012;
  localparam logic [15:0] EXTENDED_REGISTER_REGION_XO_CTRL     = 16'h4016;
  localparam logic [15:0] EXTENDED_REGISTER_REGION_OTP_READ    = 16'h4040;
  localparam int unsigned OTP_BYTES        = 16;
  localparam int unsigned PA_CAP_WIDTH     = 9;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       bit_op;
    logic [2:0] bit_sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ord_sfr_req_s;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } ord_x_req_s;

  typedef struct packed {
    logic [7:0]              lposc_trim;
    logic [PA_CAP_WIDTH-1:0] pa_cap;
    logic [7:0]              pa_trim;
    logic [7:0]              xo_ctrl;
  } ord_xregs_s;

  typedef struct packed {
    logic [SFR_COUNT-1:0][7:0] special_function_region;
    ord_xregs_s                x;
    logic [7:0]                sfr_rdata;
    logic [7:0]                x_rdata;
  } ord_state_s;

endpackage

`default_nettype wire

/* File: ord_map_chk.sv */
`default_nettype none
module ord_map_chk
  import ord_pkg::*;
#(
  parameter int unsigned FC_WIDTH = 32
)(
  input  wire logic                      clock,
  input  wire logic                      arst_n,
  input  wire ord_sfr_req_s              sfr_req,
  input  wire logic [7:0]                sfr_rdata,
  input  wire logic                      sfr_claim,
  input  wire ord_x_req_s                x_req,
  input  wire logic [7:0]                x_rdata,
  input  wire logic                      x_claim,
  input  wire logic [FC_WIDTH-1:0]       freq_counter_result,
  input  wire logic [SFR_COUNT-1:0][7:0] sfr_values,
  input  wire ord_xregs_s                extended_register_region_values
);
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  logic [31:0] fc32;
  logic        x_rd;
  assign fc32 = 32'(freq_counter_result);
  assign x_rd = x_req.rd && !x_req.wr;
  property p_sfr_low; sfr_req.addr < SFR_REGION_BASE |-> !sfr_claim; endproperty
  a_sfr_low: assert property (p_sfr_low) else $error("low address claimed");
  property p_sfr_rsv; sfr_req.rd && !sfr_claim |=> sfr_rdata == 8'h00; endproperty
  a_sfr_rsv: assert property (p_sfr_rsv) else $error("reserved read not zero");
  property p_x_span; x_claim == (x_req.addr inside {[EXTENDED_REGISTER_REGION_BASE:EXTENDED_REGISTER_REGION_LAST]}); endproperty
  a_x_span: assert property (p_x_span) else $error("extended claim wrong");
  property p_x_out; x_req.rd && !x_claim |=> x_rdata == 8'h00; endproperty
  a_x_out: assert property (p_x_out) else $error("outside read not zero");
  property p_cap_hi; x_rd && x_req.addr == EXTENDED_REGISTER_REGION_PA_CAP |=> x_rdata == {7'h00, $past(extended_register_region_values.pa_cap[8])}; endproperty
  a_cap_hi: assert property (p_cap_hi) else $error("cap upper byte wrong");
  property p_cap_wr; x_req.wr && x_req.addr == EXTENDED_REGISTER_REGION_PA_CAP |=> $stable(extended_register_region_values.pa_cap[7:0]); endproperty
  a_cap_wr: assert property (p_cap_wr) else $error("cap low bits hit");
  property p_fc_msb; x_rd && x_req.addr == EXTENDED_REGISTER_REGION_FC_RESULT |=> x_rdata == $past(fc32[31:24]); endproperty
  a_fc_msb: assert property (p_fc_msb) else $error("counter top byte wrong");
  property p_fc_lsb; x_rd && x_req.addr == EXTENDED_REGISTER_REGION_FC_RESULT + 16'h0003 |=> x_rdata == $past(fc32[7:0]); endproperty
  a_fc_lsb: assert property (p_fc_lsb) else $error("counter low byte wrong");
  property p_bit; sfr_req.wr && sfr_req.bit_op && sfr_req.addr[2:0] != 3'h0 |=> $stable(sfr_values); endproperty
  a_bit: assert property (p_bit) else $error("stray bit write stored");
endmodule
bind ord_register_map_decoder ord_map_chk #(.FC_WIDTH(FC_WIDTH)) u_chk (.clock(clock), .arst_n(arst_n),
  .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_claim(sfr_claim), .x_req(x_req), .x_rdata(x_rdata),
  .x_claim(x_claim), .freq_counter_result(freq_counter_result), .sfr_values(sfr_values), .extended_register_region_values(extended_register_region_values));
`default_nettype wire

/* File: ord_core_model.sv */
`default_nettype none
module ord_core_model
  import ord_pkg::*;
(
  input  wire logic       clock,
  input  wire logic [7:0] sfr_rdata,
  input  wire logic [7:0] x_rdata,
  output var ord_sfr_req_s sfr_req,
  output var ord_x_req_s   x_req
);
  timeunit 1ns;
  timeprecision 100ps;
  initial sfr_req = '0;
  initial x_req = '0;
  // idle cycle after each strobe so read data has landed
  task automatic special_function_region(input logic w, b, input logic [2:0] s, input logic [7:0] a, d, output logic [7:0] q);
    @(posedge clock);
    sfr_req <= '{rd: !w, wr: w, bit_op: b, bit_sel: s, addr: a, wdata: d};
    @(posedge clock);
    sfr_req <= '0;
    @(posedge clock);
    q = sfr_rdata;
  endtask
  // extended registers only through external moves
  task automatic xm(input logic w, input logic [15:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clock);
    x_req <= '{rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clock);
    x_req <= '0;
    @(posedge clock);
    q = x_rdata;
  endtask
endmodule
`default_nettype wire

/* File: ord_register_map_decoder_tb.sv */
`default_nettype none
`define CK(a, b) cmp((a) !== (b))
module ord_register_map_decoder_tb
  import ord_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic                      clock = 1'b0;
  logic                      arst_n = 1'b0;
  logic [7:0]                bit_read_value = 8'h00;
  logic [31:0]               freq_counter_result = 32'h0;
  logic [OTP_BYTES-1:0][7:0] otp_read_bytes = '0;
  ord_sfr_req_s              sfr_req;
  ord_x_req_s                x_req;
  logic [7:0]                sfr_rdata;
  logic [7:0]                x_rdata;
  logic [SFR_COUNT-1:0][7:0] sfr_values;
  ord_xregs_s                extended_register_region_values;
  logic [7:0]                q;
  int                        err_total = 0;
  int                        checked = 0;
  logic [7:0]                rsv [4] = '{8'h7F, 8'h80, 8'h8E, 8'hFF};
  logic [15:0]               xa [5] = '{16'h4002, 16'h4012, 16'h4016, 16'h4003, 16'h4017};
  ord_core_model core (.clock(clock), .sfr_rdata(sfr_rdata), .x_rdata(x_rdata), .sfr_req(sfr_req), .x_req(x_req));
  ord_register_map_decoder dut (.clock(clock), .arst_n(arst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .sfr_claim(), .x_req(x_req), .x_rdata(x_rdata), .x_claim(), .bit_read_value(bit_read_value),
    .freq_counter_result(freq_counter_result), .otp_read_bytes(otp_read_bytes), .sfr_values(sfr_values),
    .extended_register_region_values(extended_register_region_values));
  task automatic cmp(input logic bad);
    checked++;
    if (bad)
    begin
      err_total++;
      $display("Error at %0t: value mismatch", $time);
    end
  endtask
  task automatic give_verdict;
    if (err_total == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    forever #5 clock = ~clock;
  end
  // run takes about 400 cycles
  initial
  begin
    repeat (5000) @(posedge clock);
    err_total++;
    give_verdict;
  end
  initial
  begin
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    core.special_function_region(0, 0, 3'h0, 8'h84, 8'h00, q);
    `CK(q, 8'h00);
    for (int i = 0; i < SFR_COUNT; i++)
    begin
      core.special_function_region(1, 0, 3'h0, SFR_MAP[i], 8'(i) ^ 8'hA5, q);
      core.special_function_region(0, 0, 3'h0, SFR_MAP[i], 8'h00, q);
      `CK(q, 8'(i) ^ 8'hA5);
      `CK(sfr_values[i], 8'(i) ^ 8'hA5);
    end
    foreach (rsv[j])
    begin
      core.special_function_region(1, 0, 3'h0, rsv[j], 8'hFF, q);
      core.special_function_region(0, 0, 3'h0, rsv[j], 8'h00, q);
      `CK(q, 8'h00);
    end
    core.special_function_region(1, 1, 3'h1, 8'hC8, 8'h01, q);
    core.special_function_region(0, 1, 3'h1, 8'hC8, 8'h00, q);
    `CK(q, 8'h01);
    `CK(sfr_values[28], 8'hBB);
    core.special_function_region(1, 1, 3'h2, 8'hA9, 8'h01, q);
    core.special_function_region(0, 1, 3'h2, 8'hA9, 8'h00, q);
    `CK(q, 8'h00);
    `CK(sfr_values[14], 8'hAB);
    bit_read_value <= 8'h3C;
    core.special_function_region(1, 0, 3'h0, 8'h99, 8'hFF, q);
    core.special_function_region(0, 0, 3'h0, 8'h99, 8'h00, q);
    `CK(q, 8'h3C);
    core.special_function_region(0, 1, 3'h2, 8'h99, 8'h00, q);
    `CK(q, 8'h00);
    // last two entries are reserved bytes and must stay zero
    foreach (xa[j])
    begin
      core.xm(1, xa[j], 8'hC3, q);
      core.xm(0, xa[j], 8'h00, q);
      `CK(q, (j < 3) ? 8'hC3 : 8'h00);
    end
    core.xm(1, 16'h400C, 8'hFF, q);
    core.xm(1, 16'h400D, 8'h34, q);
    core.xm(0, 16'h400C, 8'h00, q);
    `CK(q, 8'h01);
    `CK(extended_register_region_values.pa_cap, 9'h134);
    core.xm(1, 16'h400C, 8'hFE, q);
    core.xm(0, 16'h400D, 8'h00, q);
    `CK(q, 8'h34);
    `CK(extended_register_region_values.pa_cap, 9'h034);
    freq_counter_result <= 32'h12345678;
    core.xm(1, 16'h4008, 8'hFF, q);
    for (int k = 0; k < 4; k++)
    begin
      core.xm(0, 16'h4008 + 16'(k), 8'h00, q);
      `CK(q, 8'(32'h12345678 >> (24 - 8 * k)));
    end
    freq_counter_result <= 32'h00ABCDEF;
    core.xm(0, 16'h4008, 8'h00, q);
    `CK(q, 8'h00);
    core.xm(0, 16'h400B, 8'h00, q);
    `CK(q, 8'hEF);
    otp_read_bytes[5] <= 8'h5A;
    core.xm(1, 16'h4045, 8'h00, q);
    core.xm(0, 16'h4045, 8'h00, q);
    `CK(q, 8'h5A);
    core.xm(0, 16'h0084, 8'h00, q);
    `CK(q, 8'h00);
    give_verdict;
  end
endmodule
`undef CK
`default_nettype wire
